/* File: hw/incdiv_pkg.sv */
// constants and types shared by the divide/increment execution unit
package incdiv_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int WORD_W = 16;
    localparam int ADDR_W = 12;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [11:0] OFS_CMD       = 12'h000;
    localparam logic [11:0] OFS_STATUS    = 12'h004;
    localparam logic [11:0] OFS_ACC_D     = 12'h008;
    localparam logic [11:0] OFS_IDX_X     = 12'h00C;
    localparam logic [11:0] OFS_STK_P     = 12'h010;
    localparam logic [11:0] OFS_CCR       = 12'h014;
    localparam logic [11:0] OFS_MEM_ADDR  = 12'h018;
    localparam logic [11:0] OFS_PROG_ADDR = 12'h01C;
    localparam logic [11:0] OFS_CFG       = 12'h020;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int STAT_BUSY    = 0;
    localparam int STAT_ILLEGAL = 1;
    localparam int CFG_OLD_CORE = 0;
    localparam int CCR_C        = 0;
    localparam int CCR_V        = 1;
    localparam int CCR_Z        = 2;
    localparam int CCR_N        = 3;
    localparam logic [7:0]  RST_CCR  = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;

    // flag update masks, order n z v c
    localparam logic [3:0] MASK_NZVC = 4'hF;
    localparam logic [3:0] MASK_NZV  = 4'hE;
    localparam logic [3:0] MASK_ZVC  = 4'h7;
    localparam logic [3:0] MASK_Z    = 4'h4;
    localparam logic [3:0] MASK_C    = 4'h1;

    // ------------------------------------------------------------
    // opcodes, prebyte in the upper byte where present
    // ------------------------------------------------------------
    localparam logic [15:0] OPC_UDIV    = 16'h1810;
    localparam logic [15:0] OPC_SDIV    = 16'h1815;
    localparam logic [15:0] OPC_INC_EXT = 16'h0072;
    localparam logic [15:0] OPC_INC_IDX = 16'h0062;
    localparam logic [15:0] OPC_INCREMENT_ACC_A    = 16'h0042;
    localparam logic [15:0] OPC_INCREMENT_ACC_B    = 16'h0052;
    localparam logic [15:0] OPC_INS     = 16'h1B81;
    localparam logic [15:0] OPC_INX     = 16'h0008;

    // ------------------------------------------------------------
    // arithmetic constants and timing
    // ------------------------------------------------------------
    localparam logic [15:0] QUO_ZERO_DIV     = 16'hFFFF;
    localparam logic [15:0] SDIV_MIN         = 16'h8000;
    localparam logic [15:0] SDIV_NEG1        = 16'hFFFF;
    localparam logic [7:0]  BYTE_OVF_OPERAND = 8'h7F;
    localparam int          CLK_PERIOD_NS    = 8;
    localparam int          DIV_CYCLES       = 12;
    localparam logic [3:0]  DIV_WAIT_LAST    = 4'(DIV_CYCLES - 3);
    localparam int          DIV_BITS_STEP    = 2;

    typedef enum logic [3:0] {
        S_IDLE, S_DECODE, S_DIV, S_DWB, S_EXEC,
        S_MRD, S_MDAT, S_MWR, S_INS1, S_INS2
    } state_t;

endpackage

/* File: hw/udiv_core.sv */
// iterative unsigned restoring divider, several quotient bits per cycle
`timescale 1ns/10ps
module udiv_core
    import incdiv_pkg::*;
#(
    parameter int WIDTH = WORD_W,
    parameter int BITS  = DIV_BITS_STEP
)(
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             start_i,
    input  wire logic [WIDTH-1:0] dividend_i,
    input  wire logic [WIDTH-1:0] divisor_i,
    output logic      [WIDTH-1:0] quo_o,
    output logic      [WIDTH-1:0] rem_o
);
    localparam int STEPS = WIDTH / BITS;

    logic [WIDTH-1:0] den_r;
    logic [4:0]       cnt_r;
    logic [WIDTH-1:0] q_nxt;
    logic [WIDTH-1:0] r_nxt;
    logic [WIDTH:0]   trial;

    // ------------------------------------------------------------
    // one step: shift in BITS dividend bits, subtract when it fits
    // ------------------------------------------------------------
    // a zero divisor yields an all-ones quotient on its own
    always_comb
    begin
        q_nxt = quo_o;
        r_nxt = rem_o;
        trial = '0;
        for (int i = 0; i < BITS; i++)
        begin
            trial = {r_nxt, q_nxt[WIDTH-1]};
            q_nxt = {q_nxt[WIDTH-2:0], 1'b0};
            if (trial >= {1'b0, den_r})
            begin
                trial    = trial - {1'b0, den_r};
                q_nxt[0] = 1'b1;
            end
            r_nxt = trial[WIDTH-1:0];
        end
    end

    // quotient register doubles as the dividend shifter
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            quo_o <= '0;
            rem_o <= '0;
            den_r <= '0;
            cnt_r <= '0;
        end
        else if (start_i)
        begin
            quo_o <= dividend_i;
            rem_o <= '0;
            den_r <= divisor_i;
            cnt_r <= 5'(STEPS);
        end
        else if (cnt_r != 5'h00)
        begin
            quo_o <= q_nxt;
            rem_o <= r_nxt;
            cnt_r <= cnt_r - 5'h01;
        end
    end

endmodule

/* File: hw/incdiv_exec.sv */
// divide and increment execution unit with an apb register slave
//
// Contract
// RQ1 - unsigned divide: quotient to x, remainder to d
// RQ2 - unsigned zero divisor sets carry, quotient all ones
// RQ3 - unsigned: z from quotient, v cleared, others kept; the code clears carry when the divisor is nonzero
// RQ4 - signed divide: signed quotient x, remainder d
// RQ5 - signed zero divisor: d, x kept, carry set
// RQ6 - only overflow: 8000 by ffff
// RQ7 - signed v set on overflow, else cleared
// RQ8 - signed n, z follow quotient when valid
// RQ9 - memory increment: read, add one, write back
// RQ10 - byte increments update n z v, keep carry
// RQ11 - v when operand was 7f, z on zero
// RQ12 - opcode 42 increments accumulator a
// RQ13 - opcode 52 increments accumulator b
// RQ14 - stack increment: add one, flags untouched
// RQ15 - older core fetches twice, newer fetch plus free
// RQ16 - opcode 08 increments x, only z updated
// RQ17 - divides take twelve cycles, busy until written
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/10ps
module incdiv_exec
    import incdiv_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    output logic      [31:0]       prdata_o,
    output logic                   pready_o,
    output logic                   pslverr_o,
    output logic      [15:0]       mem_addr_o,
    output logic                   mem_rd_o,
    output logic                   mem_wr_o,
    output logic      [7:0]        mem_wdata_o,
    input  wire logic [7:0]        mem_rdata_i,
    output logic                   prog_fetch_o,
    output logic      [15:0]       prog_addr_o,
    output logic                   busy_o
);
    state_t      state_r;
    state_t      state_nxt;
    logic [15:0] cmd_r;
    logic [15:0] d_r;
    logic [15:0] x_r;
    logic [15:0] sp_r;
    logic [7:0]  ccr_r;
    logic [15:0] op_d_r;
    logic [15:0] op_x_r;
    logic [3:0]  cnt_r;
    logic        old_core_r;
    logic        illegal_r;
    logic [15:0] quo_u;
    logic [15:0] rem_u;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] mag16(input logic [15:0] v, input logic neg);
        return neg ? (~v + 16'h0001) : v;
    endfunction

    function automatic logic [7:0] upd_ccr(input logic [7:0] old,
                                           input logic [3:0] mask,
                                           input logic [3:0] nzvc);
        logic [7:0] c;
        c = old;
        if (mask[3]) c[CCR_N] = nzvc[3];
        if (mask[2]) c[CCR_Z] = nzvc[2];
        if (mask[1]) c[CCR_V] = nzvc[1];
        if (mask[0]) c[CCR_C] = nzvc[0];
        return c;
    endfunction

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire acc_phase = psel_i & penable_i;
    wire apb_done  = acc_phase & pready_o;
    wire sel_cmd   = paddr_i == OFS_CMD;
    wire sel_stat  = paddr_i == OFS_STATUS;
    wire sel_d     = paddr_i == OFS_ACC_D;
    wire sel_x     = paddr_i == OFS_IDX_X;
    wire sel_sp    = paddr_i == OFS_STK_P;
    wire sel_ccr   = paddr_i == OFS_CCR;
    wire sel_ma    = paddr_i == OFS_MEM_ADDR;
    wire sel_pa    = paddr_i == OFS_PROG_ADDR;
    wire sel_cfg   = paddr_i == OFS_CFG;
    wire arch_reg  = sel_cmd | sel_d | sel_x | sel_sp | sel_ccr | sel_ma | sel_pa | sel_cfg;
    wire mapped    = arch_reg | sel_stat;
    // state cannot change under a running instruction, so writes are refused
    wire err_now   = ~mapped | (pwrite_i & sel_stat) | (pwrite_i & busy_o & arch_reg);
    wire wr_ok     = apb_done & pwrite_i & ~pslverr_o;
    wire cmd_go    = wr_ok & sel_cmd;

    wire [31:0] rd_data =
        sel_cmd  ? {16'h0000, cmd_r} :
        sel_stat ? {30'h00000000, illegal_r, busy_o} :
        sel_d    ? {16'h0000, d_r} :
        sel_x    ? {16'h0000, x_r} :
        sel_sp   ? {16'h0000, sp_r} :
        sel_ccr  ? {24'h000000, ccr_r} :
        sel_ma   ? {16'h0000, mem_addr_o} :
        sel_pa   ? {16'h0000, prog_addr_o} :
        sel_cfg  ? {31'h00000000, old_core_r} : 32'h00000000;

    // ------------------------------------------------------------
    // instruction decode
    // ------------------------------------------------------------
    wire in_dec  = state_r == S_DECODE;
    wire in_dwb  = state_r == S_DWB;
    wire in_exec = state_r == S_EXEC;
    wire in_mdat = state_r == S_MDAT;
    wire is_sdiv = cmd_r == OPC_SDIV;
    wire is_div  = (cmd_r == OPC_UDIV) | is_sdiv;
    wire is_mem  = (cmd_r == OPC_INC_EXT) | (cmd_r == OPC_INC_IDX);
    wire is_one  = (cmd_r == OPC_INCREMENT_ACC_A) | (cmd_r == OPC_INCREMENT_ACC_B) | (cmd_r == OPC_INX);
    wire do_increment_acc_a = in_exec & (cmd_r == OPC_INCREMENT_ACC_A);
    wire do_increment_acc_b = in_exec & (cmd_r == OPC_INCREMENT_ACC_B);
    wire do_inx  = in_exec & (cmd_r == OPC_INX);
    wire div_go  = in_dec & is_div;

    // ------------------------------------------------------------
    // divide datapath: magnitudes in, signs restored at write back
    // ------------------------------------------------------------
    udiv_core #(
        .WIDTH (WORD_W),
        .BITS  (DIV_BITS_STEP)
    ) u_div (
        .mclk_i     (mclk_i),
        .rst_i      (rst_i),
        .start_i    (div_go),
        .dividend_i (mag16(d_r, is_sdiv & d_r[15])), // RQ4
        .divisor_i  (mag16(x_r, is_sdiv & x_r[15])), // RQ4
        .quo_o      (quo_u),
        .rem_o      (rem_u)
    );

    wire        zdiv     = op_x_r == RST_WORD;
    wire        sdiv_ovf = (op_d_r == SDIV_MIN) & (op_x_r == SDIV_NEG1); // RQ6
    wire [15:0] quo_s    = mag16(quo_u, op_d_r[15] ^ op_x_r[15]); // RQ4
    wire [15:0] rem_s    = mag16(rem_u, op_d_r[15]); // remainder takes dividend sign
    wire [15:0] x_res    = zdiv ? QUO_ZERO_DIV : (is_sdiv ? quo_s : quo_u); // RQ2
    wire [15:0] d_res    = is_sdiv ? rem_s : rem_u; // RQ1
    // unsigned zero divisor leaves d as it was rather than junk
    wire        d_wb     = in_dwb & ~zdiv;
    wire        x_wb     = in_dwb & ~(is_sdiv & zdiv); // RQ5
    wire [7:0]  udiv_ccr = upd_ccr(ccr_r, MASK_ZVC,
                                   {1'b0, x_res == RST_WORD, 1'b0, zdiv}); // RQ3
    wire [7:0]  sdiv_ccr = zdiv ? upd_ccr(ccr_r, MASK_C, 4'h1) : // RQ5
                           upd_ccr(ccr_r, MASK_NZVC,
                                   {quo_s[15], quo_s == RST_WORD, sdiv_ovf, 1'b0}); // RQ8
    wire [7:0]  div_ccr  = is_sdiv ? sdiv_ccr : udiv_ccr; // RQ7

    // ------------------------------------------------------------
    // byte and word increments
    // ------------------------------------------------------------
    wire [7:0]  byte_opnd = in_mdat ? mem_rdata_i : (do_increment_acc_a ? d_r[15:8] : d_r[7:0]);
    wire [7:0]  byte_res  = byte_opnd + 8'h01; // RQ9
    wire        byte_upd  = do_increment_acc_a | do_increment_acc_b | in_mdat;
    wire [7:0]  byte_ccr  = upd_ccr(ccr_r, MASK_NZV, {byte_res[7], byte_res == 8'h00,
                                    byte_opnd == BYTE_OVF_OPERAND, 1'b0}); // RQ11
    wire [15:0] inc_x     = x_r + 16'h0001;
    wire [7:0]  inx_ccr   = upd_ccr(ccr_r, MASK_Z, {1'b0, inc_x == RST_WORD, 2'b00}); // RQ16
    wire        ins_done  = state_r == S_INS2;

    // ------------------------------------------------------------
    // architectural next values, software write first
    // ------------------------------------------------------------
    wire [15:0] d_nxt   = (wr_ok & sel_d) ? pwdata_i[15:0] :
                          d_wb    ? d_res : // RQ1
                          do_increment_acc_a ? {byte_res, d_r[7:0]} : // RQ12
                          do_increment_acc_b ? {d_r[15:8], byte_res} : d_r; // RQ13
    wire [15:0] x_nxt   = (wr_ok & sel_x) ? pwdata_i[15:0] :
                          x_wb   ? x_res : // RQ1
                          do_inx ? inc_x : x_r; // RQ16
    wire [15:0] sp_nxt  = (wr_ok & sel_sp) ? pwdata_i[15:0] :
                          ins_done ? sp_r + 16'h0001 : sp_r; // RQ14
    // byte flags keep carry because its mask bit is clear
    wire [7:0]  ccr_nxt = (wr_ok & sel_ccr) ? pwdata_i[7:0] :
                          in_dwb   ? div_ccr :
                          byte_upd ? byte_ccr : // RQ10
                          do_inx   ? inx_ccr : ccr_r;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE:   state_nxt = cmd_go ? S_DECODE : S_IDLE;
            S_DECODE: state_nxt = is_div ? S_DIV : is_mem ? S_MRD :
                                  is_one ? S_EXEC : (cmd_r == OPC_INS) ? S_INS1 : S_IDLE;
            S_DIV:    state_nxt = (cnt_r == DIV_WAIT_LAST) ? S_DWB : S_DIV; // RQ17
            S_MRD:    state_nxt = S_MDAT; // RQ9
            S_MDAT:   state_nxt = S_MWR;
            S_INS1:   state_nxt = S_INS2; // RQ15
            default:  state_nxt = S_IDLE;
        endcase
    end

    // apb response takes one wait state so outputs come from flops
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o  <= 32'h00000000;
        end
        else
        begin
            pready_o  <= acc_phase & ~pready_o;
            pslverr_o <= acc_phase & ~pready_o & err_now;
            prdata_o  <= (acc_phase & ~pready_o & ~err_now) ? rd_data : 32'h00000000;
        end
    end

    // software registers and status
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cmd_r       <= RST_WORD;
            mem_addr_o  <= RST_WORD;
            prog_addr_o <= RST_WORD;
            old_core_r  <= 1'b0;
            illegal_r   <= 1'b0;
        end
        else
        begin
            cmd_r       <= cmd_go ? pwdata_i[15:0] : cmd_r;
            mem_addr_o  <= (wr_ok & sel_ma) ? pwdata_i[15:0] : mem_addr_o;
            prog_addr_o <= (wr_ok & sel_pa) ? pwdata_i[15:0] : prog_addr_o;
            old_core_r  <= (wr_ok & sel_cfg) ? pwdata_i[CFG_OLD_CORE] : old_core_r;
            illegal_r   <= cmd_go ? 1'b0 : (in_dec & (state_nxt == S_IDLE)) | illegal_r;
        end
    end

    // architectural state and sequencer registers
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_r <= S_IDLE;
            d_r     <= RST_WORD;
            x_r     <= RST_WORD;
            sp_r    <= RST_WORD;
            ccr_r   <= RST_CCR;
            op_d_r  <= RST_WORD;
            op_x_r  <= RST_WORD;
            cnt_r   <= 4'h0;
        end
        else
        begin
            state_r <= state_nxt;
            d_r     <= d_nxt;
            x_r     <= x_nxt;
            sp_r    <= sp_nxt;
            ccr_r   <= ccr_nxt;
            op_d_r  <= div_go ? d_r : op_d_r;
            op_x_r  <= div_go ? x_r : op_x_r;
            cnt_r   <= (state_r == S_DIV) ? cnt_r + 4'h1 : 4'h0;
        end
    end

    // strobes follow the next state so they sit in flops
    always_ff @(posedge mclk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            busy_o       <= 1'b0;
            mem_rd_o     <= 1'b0;
            mem_wr_o     <= 1'b0;
            mem_wdata_o  <= 8'h00;
            prog_fetch_o <= 1'b0;
        end
        else
        begin
            busy_o       <= state_nxt != S_IDLE; // RQ17
            mem_rd_o     <= state_nxt == S_MRD;
            mem_wr_o     <= state_nxt == S_MWR; // RQ9
            mem_wdata_o  <= in_mdat ? byte_res : mem_wdata_o;
            prog_fetch_o <= (state_nxt == S_INS1) | ((state_nxt == S_INS2) & old_core_r); // RQ15
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_udiv_res;
        in_dwb & ~is_sdiv & ~zdiv |=> x_r == op_d_r / op_x_r && d_r == op_d_r % op_x_r;
    endproperty
    a_udiv_res: assert property (p_udiv_res) else $error("udiv result wrong"); // RQ1

    property p_udiv_zero;
        in_dwb & ~is_sdiv & zdiv |=> x_r == QUO_ZERO_DIV && ccr_r[CCR_C];
    endproperty
    a_udiv_zero: assert property (p_udiv_zero) else $error("udiv zero divisor"); // RQ2

    property p_udiv_ccr;
        in_dwb & ~is_sdiv |=> !ccr_r[CCR_V] && ccr_r[CCR_Z] == (x_r == RST_WORD)
            && ccr_r[7:3] == $past(ccr_r[7:3]) && ccr_r[CCR_C] == (op_x_r == RST_WORD);
    endproperty
    a_udiv_ccr: assert property (p_udiv_ccr) else $error("udiv flags wrong"); // RQ3

    property p_sdiv_res;
        in_dwb & is_sdiv & ~zdiv & ~sdiv_ovf |=> $signed(x_r) == $signed(op_d_r) /
            $signed(op_x_r) && $signed(d_r) == $signed(op_d_r) % $signed(op_x_r);
    endproperty
    a_sdiv_res: assert property (p_sdiv_res) else $error("sdiv result wrong"); // RQ4

    property p_sdiv_zero;
        in_dwb & is_sdiv & zdiv |=> x_r == op_x_r && d_r == op_d_r && ccr_r[CCR_C];
    endproperty
    a_sdiv_zero: assert property (p_sdiv_zero) else $error("sdiv zero divisor"); // RQ5

    property p_sdiv_ovf;
        in_dwb & is_sdiv & ~zdiv |=>
            ccr_r[CCR_V] == (op_d_r == SDIV_MIN && op_x_r == SDIV_NEG1);
    endproperty
    a_sdiv_ovf: assert property (p_sdiv_ovf) else $error("sdiv overflow case"); // RQ6

    property p_sdiv_v;
        in_dwb & is_sdiv & ~zdiv & ~sdiv_ovf |=> !ccr_r[CCR_V] && !ccr_r[CCR_C];
    endproperty
    a_sdiv_v: assert property (p_sdiv_v) else $error("sdiv v or c set"); // RQ7

    property p_sdiv_nz;
        in_dwb & is_sdiv & ~zdiv & ~sdiv_ovf |=>
            ccr_r[CCR_N] == x_r[15] && ccr_r[CCR_Z] == (x_r == RST_WORD);
    endproperty
    a_sdiv_nz: assert property (p_sdiv_nz) else $error("sdiv n or z wrong"); // RQ8

    property p_mem_rmw;
        mem_rd_o |=> ##1 mem_wr_o && mem_wdata_o == $past(mem_rdata_i) + 8'h01
            && $stable(mem_addr_o);
    endproperty
    a_mem_rmw: assert property (p_mem_rmw) else $error("memory increment wrong"); // RQ9

    property p_byte_c;
        mem_wr_o |-> ccr_r[CCR_C] == $past(ccr_r[CCR_C]);
    endproperty
    a_byte_c: assert property (p_byte_c) else $error("carry changed"); // RQ10

    property p_byte_vz;
        mem_wr_o |-> ccr_r[CCR_V] == ($past(mem_rdata_i) == BYTE_OVF_OPERAND)
            && ccr_r[CCR_Z] == (mem_wdata_o == 8'h00) && ccr_r[CCR_N] == mem_wdata_o[7];
    endproperty
    a_byte_vz: assert property (p_byte_vz) else $error("byte flags wrong"); // RQ11

    property p_increment_acc_a;
        do_increment_acc_a |=> d_r[15:8] == $past(d_r[15:8]) + 8'h01 && $stable(d_r[7:0]);
    endproperty
    a_increment_acc_a: assert property (p_increment_acc_a) else $error("acc a increment wrong"); // RQ12

    property p_increment_acc_b;
        do_increment_acc_b |=> d_r[7:0] == $past(d_r[7:0]) + 8'h01 && $stable(d_r[15:8])
            && $stable(ccr_r[CCR_C]);
    endproperty
    a_increment_acc_b: assert property (p_increment_acc_b) else $error("acc b increment wrong"); // RQ13

    property p_ins;
        ins_done |=> sp_r == $past(sp_r) + 16'h0001 && $stable(ccr_r) && !busy_o;
    endproperty
    a_ins: assert property (p_ins) else $error("stack increment wrong"); // RQ14

    property p_ins_fetch;
        state_r == S_INS1 |-> prog_fetch_o ##1 (prog_fetch_o == old_core_r)
            && $stable(prog_addr_o) ##1 !prog_fetch_o;
    endproperty
    a_ins_fetch: assert property (p_ins_fetch) else $error("fetch pattern wrong"); // RQ15

    property p_inx;
        do_inx |=> x_r == $past(x_r) + 16'h0001 && ccr_r[CCR_Z] == (x_r == RST_WORD)
            && ccr_r[7:3] == $past(ccr_r[7:3]) && ccr_r[1:0] == $past(ccr_r[1:0]);
    endproperty
    a_inx: assert property (p_inx) else $error("x increment wrong"); // RQ16

    property p_div_len;
        div_go |-> busy_o [*8] ##1 busy_o [*4] ##1 !busy_o;
    endproperty
    a_div_len: assert property (p_div_len) else $error("divide length wrong"); // RQ17

    c_sdiv_ovf:  cover property (in_dwb & is_sdiv & sdiv_ovf);
    c_udiv_zero: cover property (in_dwb & ~is_sdiv & zdiv);
    c_mem_ovf:   cover property (mem_wr_o && mem_wdata_o == 8'h80);
    c_old_ins:   cover property (prog_fetch_o ##1 prog_fetch_o);

endmodule

/* File: tb/tb_incdiv_exec.sv */
// self-checking testbench for the divide/increment unit
`timescale 1ns/10ps
module tb_incdiv_exec;
    import incdiv_pkg::*;
    // ----
    // signals, case table
    // ----
    logic        mclk_i = 0, rst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rv;
    logic        pready_o, pslverr_o, mem_rd_o, mem_wr_o, prog_fetch_o, busy_o, ev;
    logic [15:0] mem_addr_o, prog_addr_o, wadr;
    logic [7:0]  mem_wdata_o, wdat, mem_rdata_i = 8'h5A;
    logic [127:0] r;
    int          num_errors = 0, n_compared = 0, nf = 0, nb = 0, f0, b0;
    // op d x ccr, then expected d x ccr and busy cycles
    logic [127:0] cs [9] = '{
        128'h1810_1235_0010_0009_0005_0123_0008_000C,
        128'h1810_0042_0000_0002_0042_FFFF_0001_000C,
        128'h1810_0005_0009_0000_0005_0000_0004_000C,
        128'h1815_FFF9_0002_0007_FFFF_FFFD_0008_000C,
        128'h1815_1234_0000_0000_1234_0000_0001_000C,
        128'h1815_8000_FFFF_0000_0000_8000_000A_000C,
        128'h0042_7FFF_0000_0001_80FF_0000_000B_0002,
        128'h0052_00FF_0000_0001_0000_0000_0005_0002,
        128'h0008_0000_FFFF_000B_0000_0000_000F_0002};
    incdiv_exec DUT (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o),
        .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i),
        .prog_fetch_o(prog_fetch_o), .prog_addr_o(prog_addr_o), .busy_o(busy_o));
    initial forever #4 mclk_i = ~mclk_i;
    // memory answers after the read strobe; a toggling pattern otherwise
    always @(posedge mclk_i)
    begin
        mem_rdata_i <= mem_rd_o ? 8'h7F : ~mem_rdata_i;
        if (mem_wr_o) {wadr, wdat} <= {mem_addr_o, mem_wdata_o};
        nf <= nf + int'(prog_fetch_o);
        nb <= nb + int'(busy_o);
    end
    // ----
    // tasks
    // ----
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i) penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1 && ++n < 20);
        chk("pready", 32'h1, {31'h0, pready_o});
        rv = prdata_o;
        ev = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic stp(input logic [15:0] d, x, input logic [7:0] c);
        apb(1'b1, OFS_ACC_D, {16'h0, d});
        apb(1'b1, OFS_IDX_X, {16'h0, x});
        apb(1'b1, OFS_CCR, {24'h0, c});
    endtask
    task automatic wt();
        int n;
        n = 0;
        do apb(1'b0, OFS_STATUS, 32'h0); while (rv[STAT_BUSY] !== 1'b0 && ++n < 30);
        chk("busy", 32'h0, {31'h0, busy_o});
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rv);
    endtask
    task automatic res(input logic [15:0] d, x, input logic [7:0] c);
        rdc("acc_d", OFS_ACC_D, {16'h0, d});
        rdc("idx_x", OFS_IDX_X, {16'h0, x});
        rdc("ccr", OFS_CCR, {24'h0, c});
    endtask
    task automatic print_verdict();
        if (num_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // runaway guard, far beyond the few hundred cycles needed
    initial
    begin
        #400000;
        num_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        foreach (cs[i])
        begin
            r = cs[i];
            stp(r[111:96], r[95:80], r[71:64]);
            apb(1'b1, OFS_CMD, {16'h0, r[127:112]});
            b0 = nb;
            wt();
            chk("cycles", 32'(r[15:0]), 32'(nb - b0));
            res(r[63:48], r[47:32], r[23:16]);
        end
        for (int k = 1; k >= 0; k--)
        begin
            apb(1'b1, OFS_CFG, 32'(k));
            apb(1'b1, OFS_STK_P, 32'h00FF);
            apb(1'b1, OFS_CCR, 32'h05);
            f0 = nf;
            apb(1'b1, OFS_CMD, {16'h0, OPC_INS});
            wt();
            chk("fetches", 32'(k + 1), 32'(nf - f0));
            rdc("sp", OFS_STK_P, 32'h0100);
            rdc("ccr", OFS_CCR, 32'h05);
        end
        for (int j = 0; j < 2; j++)
        begin
            apb(1'b1, OFS_MEM_ADDR, 32'h0123);
            apb(1'b1, OFS_CCR, 32'h01);
            apb(1'b1, OFS_CMD, {16'h0, j ? OPC_INC_IDX : OPC_INC_EXT});
            wt();
            chk("wdata", 32'h80, {24'h0, wdat});
            chk("waddr", 32'h0123, {16'h0, wadr});
            rdc("ccr", OFS_CCR, 32'h0B);
        end
        // a write while busy must be refused and leave the divide intact
        stp(16'h0064, 16'h000A, 8'h00);
        apb(1'b1, OFS_CMD, {16'h0, OPC_UDIV});
        apb(1'b1, OFS_IDX_X, 32'h0007);
        chk("busy write", 32'h1, {31'h0, ev});
        wt();
        res(16'h0000, 16'h000A, 8'h00);
        apb(1'b1, 12'h024, 32'h0);
        chk("unmapped", 32'h1, {31'h0, ev});
        // an unknown opcode ends at decode and raises the illegal status bit
        apb(1'b1, OFS_CMD, 32'h0099);
        wt();
        rdc("illegal", OFS_STATUS, 32'h2);
        print_verdict();
    end
endmodule
